/* timer_map.svh */
// register offsets, field positions, reset values and timing counts of the dual half timer
// assumes APB byte addressing with one aligned 32-bit word per register
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

`define OFF_WIDTH_CFG    12'h000
`define OFF_HALF_A_MODE  12'h004
`define OFF_HALF_B_MODE  12'h008
`define OFF_CONTROL      12'h00c
`define OFF_IRQ_MASK     12'h018
`define OFF_RAW_STATUS   12'h01c
`define OFF_MASK_STATUS  12'h020
`define OFF_IRQ_CLEAR    12'h024
`define OFF_A_LOAD       12'h028
`define OFF_B_LOAD       12'h02c
`define OFF_A_MATCH      12'h030
`define OFF_B_MATCH      12'h034
`define OFF_A_PRESCALE   12'h038
`define OFF_B_PRESCALE   12'h03c
`define OFF_A_COUNT      12'h048
`define OFF_B_COUNT      12'h04c

// control register fields, half b sits 8 bits above half a
`define CTL_EN           0
`define CTL_STALL        1
`define CTL_RTC_RUN      4
`define CTL_OTE          5
`define CTL_B_SHIFT      8

// status, mask and clear fields
`define IRQ_TIMEOUT      0
`define IRQ_CLOCK_MATCH  3
`define IRQ_B_SHIFT      8

`define MODE_ONE_SHOT    2'h1
`define MODE_PERIODIC    2'h2

`define RST_LOAD         16'hffff
`define RST_PRESCALE     8'h00
`define RTC_FIRST_LOAD   32'h00000001

// the clock pin runs at 32.768 kHz and the counter advances at 1 Hz
`define RTC_IN_HZ        32768
`define RTC_OUT_HZ       1

`endif

/* timer_pkg.sv */
// types shared by the dual half timer and its clock-pin divider
// assumes timer_map.svh is compiled alongside
package timer_pkg;

   typedef enum logic [2:0]
   {
      CFG_32_TIMER = 3'h0,
      CFG_32_RTC   = 3'h1,
      CFG_16_SPLIT = 3'h4
   } width_cfg_t;

   typedef struct packed {
      width_cfg_t       cfg;
      logic [1:0][1:0]  mode;
      logic [1:0]       en;
      logic [1:0]       stall;
      logic [1:0]       ote;
      logic             rtc_run;
      logic [1:0]       im_to;
      logic             im_rtc;
      logic [1:0]       ris_to;
      logic             ris_rtc;
      logic [1:0][15:0] load;
      logic [1:0][15:0] cnt;
      logic [1:0][15:0] match;
      logic [1:0][7:0]  ps;
      logic [1:0][7:0]  pc;
      logic             rtc_seen;
      logic [31:0]      rdata;
      logic             ready;
      logic             slverr;
      logic             irq;
      logic             adc;
   } timer_state_t;

   typedef struct packed {
      logic        sync1;
      logic        sync2;
      logic        prev;
      logic [15:0] edges;
      logic        tick;
   } rtc_div_state_t;

endpackage

/* rtc_divider.sv */
// synchroniser, rising-edge detector and divider for the external real-time clock pin
// assumes the pin runs far below CLK_SYS so every level lasts several system clocks
`timescale 1ns/1ns
`default_nettype none
`include "timer_map.svh"

module rtc_divider
#(
   parameter int EDGES_PER_TICK = `RTC_IN_HZ / `RTC_OUT_HZ
)
(
   // clock and reset
   input  wire logic CLK_SYS,
   input  wire logic SRST,
   // pin side
   input  wire logic CLOCK_PIN,
   // one-cycle pulse per divided period
   output logic      TICK
);
   import timer_pkg::*;

   rtc_div_state_t st;
   rtc_div_state_t next_st;

   always_comb
   begin
      next_st = st;
      next_st.sync1 = CLOCK_PIN;
      next_st.sync2 = st.sync1;
      next_st.prev = st.sync2;
      next_st.tick = 1'b0;
      // only the second stage feeds the edge detector
      if (st.sync2 && !st.prev)
      begin
         if (st.edges == 16'(EDGES_PER_TICK - 1))
         begin
            next_st.edges = 16'h0000;
            next_st.tick = 1'b1;
         end
         else
         begin
            next_st.edges = st.edges + 16'h0001;
         end
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
         st <= '0;
      else
         st <= next_st;
   end

   assign TICK = st.tick;

   tick_spacing_a : assert property (@(posedge CLK_SYS) disable iff (SRST)
      st.tick |=> !st.tick) else $error("divider tick lasted more than one cycle");

endmodule
`default_nettype wire

/* dual_half_timer.sv */
// dual 16-bit half timer with joined 32-bit timer and real-time-clock modes, APB slave
// assumes DEBUG_HALT comes from logic on CLK_SYS; the clock pin is asynchronous
`timescale 1ns/1ns
`default_nettype none
`include "timer_map.svh"

// Functional notes
// - reset leaves block inactive, controls cleared
// - counters and loads reset to ffff
// - prescale counters and registers reset zero
// - config 0 joined timer, 1 joined clock
// - config 4 splits into two halves
// - joined load write fills both halves
// - joined count read returns both halves
// - joined timer down count, mode from half a
// - at zero reload; one-shot clears enable
// - time-out sets sticky raw, masked flags
// - adc trigger only when enabled
// - load write reaches counter next cycle
// - stall bit freezes timer and split count in halt, not clock count
// - clock mode counts up, first load one
// - clock pin divided down to 1 Hz
// - match rolls to zero, sets match flag
// - clock run bit overrides debug stall
// - split halves use 8-bit prescaler
// - half at zero reloads load, prescale
// - half time-out sets its own flags
// - prescale p gives p+1 clocks per count
module dual_half_timer
#(
   parameter int RTC_EDGES = `RTC_IN_HZ / `RTC_OUT_HZ
)
(
   // clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        SRST,
   // apb slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // system
   input  wire logic        DEBUG_HALT,
   input  wire logic        CLOCK_PIN,
   output logic             IRQ,
   output logic             ADC_TRIGGER
);
   import timer_pkg::*;

   timer_state_t st;
   timer_state_t next_st;
   logic         rtc_tick;
   logic         setup;
   logic         wr;
   logic         is32;
   logic         split;
   logic [31:0]  cnt32;
   logic [31:0]  load32;
   logic [31:0]  match32;
   logic [1:0]   halted;
   logic [1:0]   run;
   logic [1:0]   to_evt;
   logic         rtc_evt;
   logic [1:0]   clr_to;
   logic         clr_rtc;

   rtc_divider #(.EDGES_PER_TICK(RTC_EDGES)) u_div
   (
      .CLK_SYS   (CLK_SYS),
      .SRST      (SRST),
      .CLOCK_PIN (CLOCK_PIN),
      .TICK      (rtc_tick)
   );

   assign setup   = PSEL && PENABLE && !st.ready;
   assign wr      = PSEL && PENABLE && st.ready && PWRITE;
   assign is32    = (st.cfg == CFG_32_TIMER) || (st.cfg == CFG_32_RTC);
   assign split   = (st.cfg == CFG_16_SPLIT);
   assign cnt32   = {st.cnt[1], st.cnt[0]};
   assign load32  = {st.load[1], st.load[0]};
   assign match32 = {st.match[1], st.match[0]};
   assign clr_to  = {wr && PADDR == `OFF_IRQ_CLEAR && PWDATA[`IRQ_TIMEOUT + `IRQ_B_SHIFT],
                     wr && PADDR == `OFF_IRQ_CLEAR && PWDATA[`IRQ_TIMEOUT]};
   assign clr_rtc = wr && PADDR == `OFF_IRQ_CLEAR && PWDATA[`IRQ_CLOCK_MATCH];

   // per-half run and time-out; in joined timer mode half a carries the whole counter
   for (genvar i = 0; i < 2; i++)
   begin : g_half
      assign halted[i] = DEBUG_HALT && st.stall[i] && !st.rtc_run;
      assign run[i]    = st.en[i] && !halted[i];
      assign to_evt[i] = split ? (run[i] && st.pc[i] == 8'h00 && st.cnt[i] == 16'h0000)
                       : (i == 0 && st.cfg == CFG_32_TIMER && run[0] && cnt32 == 32'h00000000);
   end

   // the clock mode ignores stall bits entirely
   assign rtc_evt = st.cfg == CFG_32_RTC && st.en[0] && rtc_tick && cnt32 == match32;

   always_comb
   begin
      next_st = st;
      next_st.ready = setup;
      next_st.adc = 1'b0;

      // counting
      case (st.cfg)
         CFG_32_TIMER:
         begin
            if (run[0])
            begin
               if (to_evt[0])
               begin
                  {next_st.cnt[1], next_st.cnt[0]} = load32;
                  if (st.mode[0] == `MODE_ONE_SHOT)
                     next_st.en[0] = 1'b0;
               end
               else
               begin
                  {next_st.cnt[1], next_st.cnt[0]} = cnt32 - 32'h00000001;
               end
            end
         end
         CFG_32_RTC:
         begin
            if (st.en[0] && rtc_tick)
            begin
               if (rtc_evt)
                  {next_st.cnt[1], next_st.cnt[0]} = 32'h00000000;
               else
                  {next_st.cnt[1], next_st.cnt[0]} = cnt32 + 32'h00000001;
            end
         end
         CFG_16_SPLIT:
         begin
            for (int i = 0; i < 2; i++)
            begin
               if (run[i])
               begin
                  if (st.pc[i] != 8'h00)
                  begin
                     next_st.pc[i] = st.pc[i] - 8'h01;
                  end
                  else if (st.cnt[i] == 16'h0000)
                  begin
                     next_st.cnt[i] = st.load[i];
                     next_st.pc[i] = st.ps[i];
                     if (st.mode[i] == `MODE_ONE_SHOT)
                        next_st.en[i] = 1'b0;
                  end
                  else
                  begin
                     next_st.cnt[i] = st.cnt[i] - 16'h0001;
                     next_st.pc[i] = st.ps[i];
                  end
               end
            end
         end
         default:
         begin
            next_st.cnt = st.cnt;
         end
      endcase

      // register writes take effect at the edge that completes the access
      if (wr)
      begin
         case (PADDR)
            `OFF_WIDTH_CFG:
            begin
               next_st.cfg = width_cfg_t'(PWDATA[2:0]);
               if (width_cfg_t'(PWDATA[2:0]) == CFG_32_RTC && !st.rtc_seen)
               begin
                  {next_st.cnt[1], next_st.cnt[0]} = `RTC_FIRST_LOAD;
                  next_st.rtc_seen = 1'b1;
               end
            end
            `OFF_HALF_A_MODE: next_st.mode[0] = PWDATA[1:0];
            `OFF_HALF_B_MODE: next_st.mode[1] = PWDATA[1:0];
            `OFF_CONTROL:
            begin
               for (int i = 0; i < 2; i++)
               begin
                  next_st.en[i] = PWDATA[`CTL_EN + i * `CTL_B_SHIFT];
                  next_st.stall[i] = PWDATA[`CTL_STALL + i * `CTL_B_SHIFT];
                  next_st.ote[i] = PWDATA[`CTL_OTE + i * `CTL_B_SHIFT];
               end
               next_st.rtc_run = PWDATA[`CTL_RTC_RUN];
            end
            `OFF_IRQ_MASK:
            begin
               next_st.im_to = {PWDATA[`IRQ_TIMEOUT + `IRQ_B_SHIFT], PWDATA[`IRQ_TIMEOUT]};
               next_st.im_rtc = PWDATA[`IRQ_CLOCK_MATCH];
            end
            `OFF_A_LOAD:
            begin
               next_st.load[0] = PWDATA[15:0];
               next_st.cnt[0] = PWDATA[15:0];
               if (is32)
               begin
                  next_st.load[1] = PWDATA[31:16];
                  next_st.cnt[1] = PWDATA[31:16];
               end
            end
            `OFF_B_LOAD:
            begin
               next_st.load[1] = PWDATA[15:0];
               next_st.cnt[1] = PWDATA[15:0];
            end
            `OFF_A_MATCH:
            begin
               next_st.match[0] = PWDATA[15:0];
               if (is32)
                  next_st.match[1] = PWDATA[31:16];
            end
            `OFF_B_MATCH:    next_st.match[1] = PWDATA[15:0];
            `OFF_A_PRESCALE: next_st.ps[0] = PWDATA[7:0];
            `OFF_B_PRESCALE: next_st.ps[1] = PWDATA[7:0];
            default:         next_st.cfg = st.cfg;
         endcase
      end

      // sticky flags: a new event beats a clear in the same cycle
      next_st.ris_to = (st.ris_to & ~clr_to) | to_evt;
      next_st.ris_rtc = (st.ris_rtc & ~clr_rtc) | rtc_evt;
      next_st.irq = |(next_st.ris_to & next_st.im_to) || (next_st.ris_rtc && next_st.im_rtc);
      next_st.adc = |(to_evt & st.ote);

      // read data is captured in the setup cycle and shown with PREADY
      next_st.slverr = 1'b0;
      if (setup)
      begin
         next_st.rdata = 32'h00000000;
         case (PADDR)
            `OFF_WIDTH_CFG:   next_st.rdata[2:0] = st.cfg;
            `OFF_HALF_A_MODE: next_st.rdata[1:0] = st.mode[0];
            `OFF_HALF_B_MODE: next_st.rdata[1:0] = st.mode[1];
            `OFF_CONTROL:
            begin
               for (int i = 0; i < 2; i++)
               begin
                  next_st.rdata[`CTL_EN + i * `CTL_B_SHIFT] = st.en[i];
                  next_st.rdata[`CTL_STALL + i * `CTL_B_SHIFT] = st.stall[i];
                  next_st.rdata[`CTL_OTE + i * `CTL_B_SHIFT] = st.ote[i];
               end
               next_st.rdata[`CTL_RTC_RUN] = st.rtc_run;
            end
            `OFF_IRQ_MASK:
            begin
               next_st.rdata[`IRQ_TIMEOUT] = st.im_to[0];
               next_st.rdata[`IRQ_TIMEOUT + `IRQ_B_SHIFT] = st.im_to[1];
               next_st.rdata[`IRQ_CLOCK_MATCH] = st.im_rtc;
            end
            `OFF_RAW_STATUS, `OFF_MASK_STATUS:
            begin
               next_st.rdata[`IRQ_TIMEOUT] = st.ris_to[0] && (PADDR == `OFF_RAW_STATUS || st.im_to[0]);
               next_st.rdata[`IRQ_TIMEOUT + `IRQ_B_SHIFT] = st.ris_to[1]
                  && (PADDR == `OFF_RAW_STATUS || st.im_to[1]);
               next_st.rdata[`IRQ_CLOCK_MATCH] = st.ris_rtc && (PADDR == `OFF_RAW_STATUS || st.im_rtc);
            end
            `OFF_IRQ_CLEAR:  next_st.rdata = 32'h00000000;
            `OFF_A_LOAD:     next_st.rdata = is32 ? load32 : {16'h0000, st.load[0]};
            `OFF_B_LOAD:     next_st.rdata[15:0] = st.load[1];
            `OFF_A_MATCH:    next_st.rdata = is32 ? match32 : {16'h0000, st.match[0]};
            `OFF_B_MATCH:    next_st.rdata[15:0] = st.match[1];
            `OFF_A_PRESCALE: next_st.rdata[7:0] = st.ps[0];
            `OFF_B_PRESCALE: next_st.rdata[7:0] = st.ps[1];
            `OFF_A_COUNT:    next_st.rdata = is32 ? cnt32 : {16'h0000, st.cnt[0]};
            `OFF_B_COUNT:    next_st.rdata[15:0] = st.cnt[1];
            default:         next_st.slverr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         st <= '0;
         st.cfg <= CFG_32_TIMER;
         st.load <= {2{`RST_LOAD}};
         st.cnt <= {2{`RST_LOAD}};
         st.ps <= {2{`RST_PRESCALE}};
         st.pc <= {2{`RST_PRESCALE}};
      end
      else
      begin
         st <= next_st;
      end
   end

   assign PRDATA = st.rdata;
   assign PREADY = st.ready;
   assign PSLVERR = st.slverr;
   assign IRQ = st.irq;
   assign ADC_TRIGGER = st.adc;

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SRST);

   // reset values are checked on the first edge with reset low
   reset_idle_a : assert property ($fell(SRST) |-> st.en == 2'b00 && !st.rtc_run && st.ris_to == 2'b00)
      else $error("controls not cleared after reset");
   reset_count_a : assert property ($fell(SRST) |-> st.cnt[0] == 16'hffff && st.load[1] == 16'hffff)
      else $error("counters not all ones after reset");
   reset_prescale_a : assert property ($fell(SRST) |-> st.ps == 16'h0000 && st.pc == 16'h0000)
      else $error("prescale not zero after reset");
   one_shot_stop_a : assert property (to_evt[0] && !split && st.mode[0] == `MODE_ONE_SHOT && !wr
      |=> !st.en[0] && cnt32 == $past(load32)) else $error("joined one-shot did not stop and reload");
   timeout_flag_a : assert property (to_evt[1] && !clr_to[1] |=> st.ris_to[1] ##1 st.ris_to[1] || $past(clr_to[1]))
      else $error("half b time-out flag not held");
   adc_gate_a : assert property (ADC_TRIGGER |-> $past(|(to_evt & st.ote)))
      else $error("adc trigger without enabled time-out");
   load_write_a : assert property (wr && PADDR == `OFF_B_LOAD |=> st.cnt[1] == $past(PWDATA[15:0]))
      else $error("load write did not reach counter");
   debug_freeze_a : assert property (st.cfg != CFG_32_RTC && halted[0] && !wr
      |=> $stable(st.cnt[0]) && $stable(st.pc[0])) else $error("half a counted during debug halt");
   rtc_rollover_a : assert property (rtc_evt && !wr |=> cnt32 == 32'h00000000 && st.ris_rtc)
      else $error("clock match did not roll over");
   prescale_hold_a : assert property (split && run[1] && st.pc[1] != 8'h00 && !wr
      |=> $stable(st.cnt[1]) && st.pc[1] == $past(st.pc[1]) - 8'h01) else $error("count moved inside prescale");

   // a register write overrides the counter, so the step and reload checks below skip the cycle in which one lands
   joined_count_a : assert property (st.cfg == CFG_32_TIMER && run[0] && !to_evt[0] && !wr
      |=> cnt32 == $past(cnt32) - 32'h00000001) else $error("joined counter did not step down");
   timeout_set_a : assert property (to_evt[0] |=> st.ris_to[0])
      else $error("joined time-out flag not set");
   adc_fire_a : assert property (|(to_evt & st.ote) |=> ADC_TRIGGER)
      else $error("enabled time-out gave no adc trigger");
   split_reload_a : assert property (split && to_evt[1] && !wr
      |=> st.cnt[1] == $past(st.load[1]) && st.pc[1] == $past(st.ps[1])) else $error("half b did not reload");
   load_join_a : assert property (wr && PADDR == `OFF_A_LOAD && is32 |=> load32 == $past(PWDATA))
      else $error("joined load write not split over both halves");
   count_read_a : assert property (setup && PADDR == `OFF_A_COUNT && is32 |=> PRDATA == $past(cnt32))
      else $error("joined count read not assembled from both halves");
   clock_count_a : assert property (st.cfg == CFG_32_RTC && st.en[0] && rtc_tick && !rtc_evt && !wr
      |=> cnt32 == $past(cnt32) + 32'h00000001) else $error("clock mode did not count up on a tick");
   clock_first_load_a : assert property (wr && PADDR == `OFF_WIDTH_CFG && PWDATA[2:0] == 3'h1
      && !st.rtc_seen |=> cnt32 == `RTC_FIRST_LOAD) else $error("first clock mode selection did not load one");

endmodule
`default_nettype wire

/* clock_pin_source.sv */
// free-running 32.768 kHz source for the timer's clock pin
// assumes a 1 ns time unit; its phase is unrelated to the system clock
`timescale 1ns/1ns
`default_nettype none

module clock_pin_source
#(
   parameter int HALF_NS  = 15259,
   parameter int START_NS = 7
)
(
   // pin side
   output logic pin
);
   // a crystal source runs free, so there are no idle gaps between periods
   initial
   begin
      pin = 1'b0;
      #(START_NS);
      forever
      begin
         #(HALF_NS) pin = ~pin;
      end
   end
endmodule
`default_nettype wire

/* dual_half_timer_tb.sv */
// self-checking bench for dual_half_timer: apb master, reference expectations, watchdog
// assumes clock_pin_source drives the clock pin and timer_map.svh gives the register map
`timescale 1ns/1ns
`default_nettype none
`include "timer_map.svh"

module dual_half_timer_tb;
   import timer_pkg::*;
   // few pin edges per tick keep the clock-mode run short
   localparam int EDGES = 4;
   logic        clk_sys = 1'b0;
   logic        srst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        debug_halt = 1'b0;
   logic        clock_pin;
   logic        irq;
   logic        adc_trigger;
   int          errors = 0;
   int          checks_done = 0;
   int          seed = 32'h346a;
   int          adc_pulses = 0;
   int          adc_gap = 0;
   int          since = 0;

   always #25 clk_sys = ~clk_sys;

   clock_pin_source src_u (.pin(clock_pin));

   dual_half_timer #(.RTC_EDGES(EDGES)) dut_u
   (
      .CLK_SYS(clk_sys), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .DEBUG_HALT(debug_halt), .CLOCK_PIN(clock_pin), .IRQ(irq), .ADC_TRIGGER(adc_trigger)
   );

   // reference for trigger spacing: cycles between the last two pulses
   always @(posedge clk_sys)
   begin
      since <= since + 1;
      if (adc_trigger === 1'b1)
      begin
         adc_pulses <= adc_pulses + 1;
         adc_gap <= since + 1;
         since <= 0;
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      // no cycle budget here: the watchdog ends a hung access
      while (pready !== 1'b1)
      begin
         @(posedge clk_sys);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] addr, input logic [31:0] d);
      logic [31:0] v;
      logic        e;
      apb(1'b1, addr, d, v, e);
   endtask

   task automatic rd(input logic [11:0] addr, output logic [31:0] v);
      logic e;
      apb(1'b0, addr, 32'h0, v, e);
   endtask

   task automatic rdchk(input logic [11:0] addr, input logic [31:0] exp);
      logic [31:0] v;
      rd(addr, v);
      chk(v, exp);
   endtask

   task automatic wait_adc(input int k, input int lim);
      int start = adc_pulses;
      int n = 0;
      while (adc_pulses < start + k && n < lim)
      begin
         @(posedge clk_sys);
         n++;
      end
      if (adc_pulses < start + k)
      begin
         errors++;
         $display("MISMATCH at %0t: trigger wait expired", $time);
      end
   endtask

   task automatic wait_irq(input int lim, output int n);
      n = 0;
      while (irq !== 1'b1 && n < lim)
      begin
         @(posedge clk_sys);
         n++;
      end
   endtask

   task automatic conclude;
      $display("comparisons %0d, mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // the whole sequence needs under 15000 cycles
   initial
   begin
      #(2000000);
      errors++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      conclude;
   end

   initial
   begin : main
      logic [31:0] v;
      logic        e;
      int          n32;
      int          big;
      int          p;
      int          ld;
      int          p0;
      int          n;
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      rdchk(`OFF_WIDTH_CFG, {29'h0, CFG_32_TIMER});
      rdchk(`OFF_CONTROL, 32'h0);
      rdchk(`OFF_RAW_STATUS, 32'h0);
      rdchk(`OFF_A_LOAD, 32'hffffffff);
      rdchk(`OFF_A_COUNT, 32'hffffffff);
      rdchk(`OFF_A_PRESCALE, 32'h0);
      rdchk(`OFF_B_PRESCALE, 32'h0);
      apb(1'b1, 12'h040, $random(seed), v, e);
      chk({31'h0, e}, 32'h1);
      apb(1'b0, 12'h040, 32'h0, v, e);
      chk({31'h0, e}, 32'h1);
      chk(v, 32'h0);
      // joined load and count span both halves
      n32 = $random(seed) | 32'h00010001;
      wr(`OFF_A_LOAD, n32);
      rdchk(`OFF_A_LOAD, n32);
      rdchk(`OFF_A_COUNT, n32);
      // joined one-shot with trigger enabled
      n32 = 8 + ($random(seed) & 31);
      wr(`OFF_A_LOAD, n32);
      wr(`OFF_HALF_A_MODE, {30'h0, `MODE_ONE_SHOT});
      wr(`OFF_IRQ_MASK, 32'h1);
      p0 = adc_pulses;
      wr(`OFF_CONTROL, 32'h21);
      wait_irq(n32 + 20, n);
      chk({31'h0, irq}, 32'h1);
      rdchk(`OFF_CONTROL, 32'h20);
      rdchk(`OFF_A_COUNT, n32);
      rdchk(`OFF_RAW_STATUS, 32'h1);
      rdchk(`OFF_MASK_STATUS, 32'h1);
      chk(adc_pulses - p0, 1);
      wr(`OFF_IRQ_CLEAR, 32'h1);
      rdchk(`OFF_RAW_STATUS, 32'h0);
      chk({31'h0, irq}, 32'h0);
      // joined periodic: period is load plus one cycles
      wr(`OFF_HALF_A_MODE, {30'h0, `MODE_PERIODIC});
      wr(`OFF_CONTROL, 32'h21);
      wait_adc(3, 3 * (n32 + 1) + 40);
      chk(adc_gap, n32 + 1);
      rdchk(`OFF_CONTROL, 32'h21);
      big = 32'h100 + ($random(seed) & 32'hff);
      wr(`OFF_A_LOAD, big);
      rd(`OFF_A_COUNT, v);
      chk({31'h0, (v <= big) && (v + 8 >= big)}, 32'h1);
      // trigger disabled: time-outs still happen but no pulse
      wr(`OFF_CONTROL, 32'h1);
      wr(`OFF_A_LOAD, n32);
      p0 = adc_pulses;
      repeat (3 * (n32 + 1) + 4) @(posedge clk_sys);
      chk(adc_pulses - p0, 0);
      rdchk(`OFF_RAW_STATUS, 32'h1);
      // stall during halt freezes the loaded count
      debug_halt <= 1'b1;
      wr(`OFF_CONTROL, 32'h3);
      wr(`OFF_A_LOAD, big);
      rdchk(`OFF_A_COUNT, big);
      rdchk(`OFF_A_COUNT, big);
      debug_halt <= 1'b0;
      rd(`OFF_A_COUNT, v);
      chk({31'h0, v < big}, 32'h1);
      wr(`OFF_CONTROL, 32'h0);
      wr(`OFF_IRQ_CLEAR, 32'h109);
      // split halves: b periodic with prescaler
      p = 1 + ($random(seed) & 7);
      ld = 3 + ($random(seed) & 7);
      wr(`OFF_WIDTH_CFG, {29'h0, CFG_16_SPLIT});
      rdchk(`OFF_WIDTH_CFG, {29'h0, CFG_16_SPLIT});
      wr(`OFF_HALF_B_MODE, {30'h0, `MODE_PERIODIC});
      wr(`OFF_B_PRESCALE, p);
      wr(`OFF_B_LOAD, ld);
      wr(`OFF_IRQ_MASK, 32'h100);
      wr(`OFF_CONTROL, 32'h2100);
      wait_adc(3, 3 * (ld + 1) * (p + 1) + 40);
      chk(adc_gap, (ld + 1) * (p + 1));
      rdchk(`OFF_RAW_STATUS, 32'h100);
      chk({31'h0, irq}, 32'h1);
      rdchk(`OFF_B_PRESCALE, p);
      rdchk(`OFF_B_LOAD, ld);
      rdchk(`OFF_A_LOAD, big);
      wr(`OFF_CONTROL, 32'h0);
      wr(`OFF_IRQ_CLEAR, 32'h109);
      // clock mode: runs through a stalled halt, 1 -> 2 -> 0 at match
      wr(`OFF_WIDTH_CFG, {29'h0, CFG_32_RTC});
      rdchk(`OFF_A_COUNT, `RTC_FIRST_LOAD);
      wr(`OFF_A_MATCH, 32'h2);
      wr(`OFF_IRQ_MASK, 32'h8);
      debug_halt <= 1'b1;
      wr(`OFF_CONTROL, 32'h13);
      wait_irq(6000, n);
      chk({31'h0, (n >= 2400) && (n <= 4900)}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      rdchk(`OFF_RAW_STATUS, 32'h8);
      rdchk(`OFF_A_COUNT, 32'h0);
      wr(`OFF_IRQ_CLEAR, 32'h8);
      rdchk(`OFF_RAW_STATUS, 32'h0);
      chk({31'h0, irq}, 32'h0);
      debug_halt <= 1'b0;
      conclude;
   end
endmodule
`default_nettype wire
